// *** hdl/eeprom_ecc_core.sv ***
// What this block does
// - ignore instructions until power-on reset settles
// - power-on reset clears write enable latch
// - power-on reset clears write-cycle-active flag
// - guard bits keep stored values through reset
// - after reset standby, deselected, no hold
// - drive serial output only while selected
// - one check word per aligned four-byte group
// - reads correct any single bit error
// - byte write rewrites whole four-byte group
// - factory state fills array with FFh
// - factory state clears all guard bits
// - factory state loads identification code bytes
`timescale 1ns/1ns
`default_nettype none
module eeprom_ecc_core #(
	parameter int WRITE_CYCLES = eeprom_ecc_pkg::WRITE_TIME_US * 1000 / eeprom_ecc_pkg::CLK_PERIOD_NS
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic chipSelN,
	input wire logic serialClk,
	input wire logic holdN,
	output logic serialOut,
	output logic serialOutEn,
	output logic standby
);
	import eeprom_ecc_pkg::*;

	// check bits: xor of code positions of set data bits
	function automatic logic [ECC_W-1:0] eccEncode(input logic [DATA_W-1:0] d);
		logic [ECC_W-1:0] c;
		int k;
		c = '0;
		k = 0;
		for (int p = 1; p <= CODE_LEN; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[k]) c = c ^ p[ECC_W-1:0];
				k++;
			end
		end
		return c;
	endfunction

	// flip the data bit named by the syndrome
	function automatic logic [DATA_W-1:0] eccCorrect(input logic [DATA_W-1:0] d, input logic [ECC_W-1:0] c);
		logic [ECC_W-1:0] s;
		logic [DATA_W-1:0] r;
		int k;
		s = eccEncode(d) ^ c;
		r = d;
		k = 0;
		for (int p = 1; p <= CODE_LEN; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (s == p[ECC_W-1:0]) r[k] = ~r[k];
				k++;
			end
		end
		return r;
	endfunction

	// array, no reset: contents are non-volatile
	logic [CODE_LEN-1:0] mem [GROUPS];
	logic [7:0] idPage [ID_BYTES];
	guard_s guards; // non-volatile guard bits
	logic porReady; // reset settled
	logic [7:0] porCount;
	seq_e state;
	logic [CNT_W-1:0] timer; // write cycle countdown
	logic [GRP_W-1:0] factGrp, pendGrp; // factory fill pointer, group to commit
	logic [ADDR_W-1:0] addrReg;
	logic [7:0] wdataReg, rdataReg, shiftReg; // write data, read data, output shifter
	logic eccFixed, writeEnableLatchFlag, writeCycleActiveFlag; // correction, latch and busy flags
	logic [DATA_W-1:0] pendWord; // merged group awaiting commit
	logic wrPend; // write data phase pending
	logic [7:0] wrAddr;
	logic [1:0] csSync, holdSync; // two-stage pin synchronisers
	logic [2:0] sckSync; // third stage keeps the previous clock level
	logic holdActive, selected;

	// current group read and corrected
	logic [GRP_W-1:0] curGrp;
	logic [1:0] lane;
	logic [CODE_LEN-1:0] rawCode;
	logic [DATA_W-1:0] corrWord, mergeWord; // corrected group, group with new byte merged
	assign curGrp = addrReg[ADDR_W-1:2];
	assign lane = addrReg[1:0];
	assign rawCode = mem[curGrp];
	assign corrWord = eccCorrect(rawCode[DATA_W-1:0], rawCode[CODE_LEN-1:DATA_W]);
	always_comb begin
		// replace one lane, keep the other three
		mergeWord = corrWord;
		mergeWord[lane*8 +: 8] = wdataReg;
	end

	// command strobe from the bus data phase
	logic [7:0] cmdVal; // command byte in the data phase
	logic cmdStrobe, cmdTake, commit, factDone, wrsrDo; // command decode
	assign cmdStrobe = wrPend && (wrAddr == REG_CMD);
	assign cmdVal = hwdata[7:0];
	assign cmdTake = cmdStrobe && porReady && (state == S_IDLE);
	assign commit = (state == S_PROG) && (timer == '0);
	assign factDone = (state == S_FACT) && (factGrp == GRP_W'(GROUPS - 1));
	assign wrsrDo = cmdTake && (cmdVal == CMD_WRSR) && writeEnableLatchFlag && !guards.statusWriteGuard;

	// power-on settle counter
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			porCount <= '0;
			porReady <= 1'b0;
		end else if (!porReady) begin
			porCount <= porCount + 8'h01;
			porReady <= (porCount == 8'(POR_CYCLES - 1));
		end
	end

	// AHB-Lite slave: zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPend <= 1'b0;
			wrAddr <= '0;
			hrdata <= '0;
		end else if (hready) begin
			wrPend <= hsel && (htrans == HTRANS_NONSEQ) && hwrite;
			wrAddr <= haddr[7:0];
			if (hsel && (htrans == HTRANS_NONSEQ) && !hwrite) begin
				case (haddr[7:0])
					REG_ADDR: hrdata <= {20'h00000, addrReg};
					REG_WDATA: hrdata <= {24'h000000, wdataReg};
					REG_RDATA: hrdata <= {24'h000000, rdataReg};
					REG_STATUS: begin
						hrdata <= '0;
						hrdata[STAT_BUSY] <= writeCycleActiveFlag;
						hrdata[STAT_WR_ENABLE] <= writeEnableLatchFlag;
						hrdata[STAT_GUARD_LOW] <= guards.blockGuardLow;
						hrdata[STAT_GUARD_HIGH] <= guards.blockGuardHigh;
						hrdata[STAT_STATUS_GUARD] <= guards.statusWriteGuard;
						hrdata[STAT_READY] <= porReady;
						hrdata[STAT_FIXED] <= eccFixed;
						hrdata[STAT_SELECTED] <= selected;
					end
					// unmapped and write-only read zero
					default: hrdata <= '0;
				endcase
			end
		end
	end

	// address and write data registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			addrReg <= '0;
			wdataReg <= '0;
		end else if (wrPend && (wrAddr == REG_ADDR)) begin
			addrReg <= hwdata[ADDR_W-1:0];
		end else if (wrPend && (wrAddr == REG_WDATA)) begin
			wdataReg <= hwdata[7:0];
		end
	end

	// sequencer: idle, program timer, factory fill
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			timer <= '0;
			factGrp <= '0;
			pendWord <= '0;
			pendGrp <= '0;
		end else begin
			case (state)
				S_IDLE: begin
					if (cmdTake && (cmdVal == CMD_WRITE) && writeEnableLatchFlag) begin
						pendWord <= mergeWord;
						pendGrp <= curGrp;
						timer <= CNT_W'(WRITE_CYCLES - 1);
						state <= S_PROG;
					end else if (cmdTake && (cmdVal == CMD_FACTORY)) begin
						factGrp <= '0;
						state <= S_FACT;
					end
				end
				S_PROG: begin
					timer <= timer - CNT_W'(1);
					if (commit) state <= S_IDLE;
				end
				S_FACT: begin
					factGrp <= factGrp + GRP_W'(1);
					if (factDone) state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// array and id page writes
	always_ff @(posedge sys_clk) begin
		if (commit) mem[pendGrp] <= {eccEncode(pendWord), pendWord};
		else if (state == S_FACT) mem[factGrp] <= {eccEncode(ERASED_WORD), ERASED_WORD};
		else if (cmdTake && (cmdVal == CMD_FLIP)) begin
			// fault injection for the corrector
			mem[curGrp][wdataReg[5:0]] <= ~rawCode[wdataReg[5:0]];
		end
		if (factDone) begin
			for (int i = 0; i < ID_BYTES; i++) begin
				idPage[i] <= (i < 3) ? ID_CODE[(2 - i)*8 +: 8] : ERASED_BYTE;
			end
		end
	end

	// guard bits: no reset, kept through power-on
	always_ff @(posedge sys_clk) begin
		if (factDone) guards <= '0;
		else if (wrsrDo) begin
			guards.statusWriteGuard <= wdataReg[STAT_STATUS_GUARD];
			guards.blockGuardHigh <= wdataReg[STAT_GUARD_HIGH];
			guards.blockGuardLow <= wdataReg[STAT_GUARD_LOW];
		end
	end

	// status flags cleared by power-on reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			writeEnableLatchFlag <= 1'b0;
			writeCycleActiveFlag <= 1'b0;
		end else begin
			writeCycleActiveFlag <= (state != S_IDLE) && !commit && !factDone;
			if (cmdTake && (cmdVal == CMD_WRITE)) writeCycleActiveFlag <= writeEnableLatchFlag;
			if (commit || wrsrDo || (cmdTake && (cmdVal == CMD_WRDI))) writeEnableLatchFlag <= 1'b0;
			else if (cmdTake && (cmdVal == CMD_WREN)) writeEnableLatchFlag <= 1'b1;
		end
	end

	// read data and correction flag
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdataReg <= '0;
			eccFixed <= 1'b0;
		end else if (cmdTake && (cmdVal == CMD_READ)) begin
			rdataReg <= corrWord[lane*8 +: 8];
			eccFixed <= (corrWord != rawCode[DATA_W-1:0]);
		end else if (cmdTake && (cmdVal == CMD_RDID)) begin
			rdataReg <= idPage[addrReg[ID_W-1:0]];
		end
	end

	// pin synchronisers: logic reads only the second stage and later
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			csSync <= 2'h3;
			sckSync <= 3'h0;
			holdSync <= 2'h3;
		end else begin
			csSync <= {csSync[0], chipSelN};
			sckSync <= {sckSync[1:0], serialClk};
			holdSync <= {holdSync[0], holdN};
		end
	end

	// selection, hold and output shifter
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			selected <= 1'b0;
			holdActive <= 1'b0;
			shiftReg <= '0;
		end else begin
			selected <= porReady && !csSync[1];
			holdActive <= porReady && !csSync[1] && !holdSync[1];
			if (cmdTake && ((cmdVal == CMD_READ) || (cmdVal == CMD_RDID))) begin
				shiftReg <= (cmdVal == CMD_READ) ? corrWord[lane*8 +: 8] : idPage[addrReg[ID_W-1:0]];
			end else if (selected && !holdActive && sckSync[1] && !sckSync[2]) begin
				shiftReg <= {shiftReg[6:0], shiftReg[7]};
			end
		end
	end

	assign serialOut = shiftReg[7];
	assign serialOutEn = selected && !holdActive;
	assign standby = !selected && !writeCycleActiveFlag;

	// checks
	property p_ignore_por;
		@(posedge sys_clk) disable iff (!rst_n) (cmdStrobe && !porReady) |=> (state == S_IDLE && $stable(writeEnableLatchFlag));
	endproperty
	a_ignore_por: assert property (p_ignore_por) else $error("command taken before reset settled");
	property p_wel_por;
		@(posedge sys_clk) disable iff (!rst_n) !porReady |-> !writeEnableLatchFlag;
	endproperty
	a_wel_por: assert property (p_wel_por) else $error("write enable latch set during reset");
	property p_wip_por;
		@(posedge sys_clk) disable iff (!rst_n) !porReady |-> (!writeCycleActiveFlag && state == S_IDLE);
	endproperty
	a_wip_por: assert property (p_wip_por) else $error("write cycle active during reset");
	property p_guard_keep;
		@(posedge sys_clk) disable iff (!rst_n) (!factDone && !wrsrDo) |=> (guards === $past(guards));
	endproperty
	a_guard_keep: assert property (p_guard_keep) else $error("guard bits changed without cause");
	property p_standby;
		@(posedge sys_clk) disable iff (!rst_n) !porReady |-> (standby && !selected && !holdActive);
	endproperty
	a_standby: assert property (p_standby) else $error("not idle after reset");
	property p_drive;
		@(posedge sys_clk) disable iff (!rst_n) $past(chipSelN, 3) |-> !serialOutEn;
	endproperty
	a_drive: assert property (p_drive) else $error("serial output driven while deselected");
	property p_ecc_word;
		@(posedge sys_clk) disable iff (!rst_n) commit |=> (mem[$past(pendGrp)][CODE_LEN-1:DATA_W] == eccEncode(mem[$past(pendGrp)][DATA_W-1:0]));
	endproperty
	a_ecc_word: assert property (p_ecc_word) else $error("group check bits wrong after write");
	property p_merge;
		@(posedge sys_clk) disable iff (!rst_n) (state == S_IDLE && cmdTake && cmdVal == CMD_WRITE && writeEnableLatchFlag) |=> (state == S_PROG && pendWord[$past(lane)*8 +: 8] == $past(wdataReg) && writeCycleActiveFlag);
	endproperty
	a_merge: assert property (p_merge) else $error("group merge or write start wrong");
	property p_fact_fill;
		@(posedge sys_clk) disable iff (!rst_n) factDone |=> (mem[0][DATA_W-1:0] == ERASED_WORD && guards == '0 && idPage[0] == ID_CODE[23:16]);
	endproperty
	a_fact_fill: assert property (p_fact_fill) else $error("factory state wrong");
	property p_read_fix;
		@(posedge sys_clk) disable iff (!rst_n) (cmdTake && cmdVal == CMD_READ) |=> (rdataReg == $past(corrWord[lane*8 +: 8]));
	endproperty
	a_read_fix: assert property (p_read_fix) else $error("read data not corrected");
	c_write: cover property (@(posedge sys_clk) disable iff (!rst_n) commit);
	c_fixed: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(eccFixed));
	c_factory: cover property (@(posedge sys_clk) disable iff (!rst_n) factDone);
endmodule
`default_nettype wire

// *** pkg/eeprom_ecc_pkg.sv ***
`default_nettype none
package eeprom_ecc_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int POR_SETTLE_NS = 1000;
	localparam int POR_CYCLES = (POR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_TIME_US = 1000;
	// array geometry
	localparam int ADDR_W = 12;
	localparam int GRP_W = 10;
	localparam int GROUPS = 1024;
	localparam int DATA_W = 32;
	localparam int ECC_W = 6;
	localparam int CODE_LEN = 38;
	localparam int ID_BYTES = 32;
	localparam int ID_W = 5;
	localparam int CNT_W = 20;
	localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// identification code, value arbitrary
	localparam logic [23:0] ID_CODE = 24'h5AA53C;
	// register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	// command codes
	localparam logic [7:0] CMD_READ = 8'h01;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_WREN = 8'h03;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_WRSR = 8'h05;
	localparam logic [7:0] CMD_RDID = 8'h06;
	localparam logic [7:0] CMD_FACTORY = 8'h07;
	localparam logic [7:0] CMD_FLIP = 8'h08;
	// status and guard bit positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_WR_ENABLE = 1;
	localparam int STAT_GUARD_LOW = 2;
	localparam int STAT_GUARD_HIGH = 3;
	localparam int STAT_STATUS_GUARD = 7;
	localparam int STAT_READY = 8;
	localparam int STAT_FIXED = 9;
	localparam int STAT_SELECTED = 10;
	// bus constants
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
	// non-volatile guard bits
	typedef struct packed {
		logic statusWriteGuard;
		logic blockGuardHigh;
		logic blockGuardLow;
	} guard_s;
	typedef enum logic [1:0] {S_IDLE, S_PROG, S_FACT} seq_e;
endpackage
`default_nettype wire

// *** verif/spi_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
	input wire logic sys_clk,
	input wire logic serialOut,
	input wire logic serialOutEn,
	output logic chipSelN,
	output logic serialClk,
	output logic holdN
);
	logic lastQ = 1'b0; // last level the device drove on the data line
	logic line; // data line as the master sees it
	// no pull on the line: once released it shows the inverse of its last level
	assign line = serialOutEn ? serialOut : ~lastQ;
	always @(posedge sys_clk)
		if (serialOutEn) lastQ <= serialOut;
	// idle: deselected, clock low, no hold
	initial begin
		chipSelN = 1'b1;
		serialClk = 1'b0;
		holdN = 1'b1;
	end
	// only this one device is ever selected on the bus
	task automatic pins(input logic cs, input logic hold);
		@(posedge sys_clk);
		chipSelN <= cs;
		holdN <= hold;
		repeat (6) @(posedge sys_clk);
	endtask
	// clock in eight bits msb first; clock stands low outside the frame
	task automatic get_byte(output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			b[i] = line;
			serialClk <= 1'b1;
			repeat (6) @(posedge sys_clk);
			serialClk <= 1'b0;
			repeat (6) @(posedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import eeprom_ecc_pkg::*;
	logic sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp; // bus control
	logic [31:0] haddr, hwdata, hrdata; // bus address and data
	logic [1:0] htrans; // transfer kind
	logic [2:0] hsize; // always a word
	logic chipSelN, serialClk, holdN, serialOut, serialOutEn, standby; // serial pins
	int mismatches, comparisons, cycles; // score and watchdog
	logic [31:0] r; // last bus read
	logic [7:0] sb; // byte taken from the serial line
	assign hready = hreadyout; // single slave drives the bus ready
	eeprom_ecc_core #(.WRITE_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chipSelN(chipSelN), .serialClk(serialClk),
		.holdN(holdN), .serialOut(serialOut), .serialOutEn(serialOutEn), .standby(standby));
	spi_master_model host (.sys_clk(sys_clk), .serialOut(serialOut), .serialOutEn(serialOutEn),
		.chipSelN(chipSelN), .serialClk(serialClk), .holdN(holdN));
	// 50 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// watchdog against a hung wait
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			$display("MISMATCH at %0t: watchdog expired", $time);
			finish_test();
		end
	end
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		r = hrdata;
		chk(hresp, HRESP_OKAY, "response");
	endtask
	task automatic cmd(input logic [7:0] c);
		bus(1'b1, REG_CMD, {24'h000000, c});
	endtask
	// fetch one byte through READ or RDID
	task automatic rdbyte(input logic [7:0] c, input logic [11:0] a);
		bus(1'b1, REG_ADDR, {20'h00000, a});
		cmd(c);
		bus(1'b0, REG_RDATA, 32'h00000000);
	endtask
	// poll a status bit until it takes a level
	task automatic poll(input int b, input logic v);
		for (int i = 0; i < 300; i++) begin
			bus(1'b0, REG_STATUS, 32'h00000000);
			if (r[b] === v)
				return;
		end
		chk(r[b], v, "status poll");
	endtask
	task automatic t_por();
		cmd(CMD_WREN);
		bus(1'b0, REG_STATUS, 32'h00000000);
		chk(r & 32'h00000103, 32'h00000000, "early command");
		poll(STAT_READY, 1'b1);
		bus(1'b0, REG_STATUS, 32'h00000000);
		chk(r & 32'h00000403, 32'h00000000, "flags after reset");
		chk({standby, serialOutEn}, 32'h00000002, "standby deselected");
		bus(1'b0, 8'h20, 32'h00000000);
		chk(r, 32'h00000000, "unmapped read");
		$display("test por done");
	endtask
	task automatic t_factory();
		cmd(CMD_FACTORY);
		repeat (1100) @(posedge sys_clk);
		rdbyte(CMD_READ, 12'h000);
		chk(r, 32'h000000FF, "erased first byte");
		rdbyte(CMD_READ, 12'hFFF);
		chk(r, 32'h000000FF, "erased last byte");
		bus(1'b0, REG_STATUS, 32'h00000000);
		chk(r & 32'h0000008C, 32'h00000000, "guards cleared");
		for (int i = 0; i < 3; i++) begin
			rdbyte(CMD_RDID, i[11:0]);
			chk(r, {24'h000000, ID_CODE[23-8*i -: 8]}, "id byte");
		end
		$display("test factory done");
	endtask
	task automatic t_write();
		cmd(CMD_WREN);
		bus(1'b1, REG_ADDR, 32'h00000005);
		bus(1'b1, REG_WDATA, 32'h0000003C);
		cmd(CMD_WRITE);
		poll(STAT_BUSY, 1'b0);
		bus(1'b0, REG_STATUS, 32'h00000000);
		chk(r[STAT_WR_ENABLE], 1'b0, "latch after write");
		for (int a = 4; a < 8; a++) begin
			rdbyte(CMD_READ, a[11:0]);
			chk(r, (a == 5) ? 32'h0000003C : 32'h000000FF, "group byte");
		end
		$display("test write done");
	endtask
	// corrupt one code bit of a group, read a byte, check value and fix flag
	task automatic flip_read(input logic [11:0] fa, input logic [5:0] fb, input logic [11:0] ra,
		input logic [7:0] e, input logic fx);
		bus(1'b1, REG_ADDR, {20'h00000, fa});
		bus(1'b1, REG_WDATA, {26'h0000000, fb});
		cmd(CMD_FLIP);
		rdbyte(CMD_READ, ra);
		chk(r, {24'h000000, e}, "corrected byte");
		bus(1'b0, REG_STATUS, 32'h00000000);
		chk(r[STAT_FIXED], fx, "fix flag");
	endtask
	task automatic t_ecc();
		flip_read(12'h004, 6'h03, 12'h005, 8'h3C, 1'b1);
		flip_read(12'h008, 6'h24, 12'h009, 8'hFF, 1'b0);
		flip_read(12'h00C, 6'h08, 12'h010, 8'hFF, 1'b0);
		rdbyte(CMD_READ, 12'h00F);
		chk(r, 32'h000000FF, "group end byte");
		$display("test ecc done");
	endtask
	task automatic t_serial();
		rdbyte(CMD_READ, 12'h005);
		host.pins(1'b0, 1'b1);
		chk({serialOutEn, standby}, 32'h00000002, "selected drive");
		host.get_byte(sb);
		chk(sb, 8'h3C, "serial byte");
		host.pins(1'b0, 1'b0);
		chk(serialOutEn, 1'b0, "held line");
		host.pins(1'b1, 1'b1);
		chk({serialOutEn, standby}, 32'h00000001, "released line");
		$display("test serial done");
	endtask
	task automatic t_guard_reset();
		cmd(CMD_WREN);
		bus(1'b1, REG_WDATA, 32'h0000008C);
		cmd(CMD_WRSR);
		cmd(CMD_WREN);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk({standby, serialOutEn}, 32'h00000002, "during reset");
		rst_n <= 1'b1;
		poll(STAT_READY, 1'b1);
		bus(1'b0, REG_STATUS, 32'h00000000);
		chk(r & 32'h0000008F, 32'h0000008C, "guards kept");
		$display("test guard reset done");
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h00000000;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_por();
		t_factory();
		t_write();
		t_ecc();
		t_serial();
		t_guard_reset();
		finish_test();
	end
endmodule
`default_nettype wire
